// ---- hdl/hswl_pkg.sv ----
// constants, timing counts and state types shared by both link ends
// assumes a single 250 MHz clock and an open-drain line with a pull-up
package hswl_pkg;
  localparam int CLK_MHZ        = 250;
  localparam int CNT_W          = 28;
  localparam int BYTE_W         = 8;
  localparam int FRAME_BITS     = 40;
  localparam int BIT_IDX_W      = 6;
  localparam int START_LOW_MS   = 18;
  localparam int RESP_DLY_MIN_US = 20;
  localparam int RESP_DLY_MAX_US = 40;
  localparam int RESP_DLY_US    = 30;
  localparam int RESP_LOW_US    = 80;
  localparam int RESP_HIGH_US   = 80;
  localparam int BIT_LOW_US     = 50;
  localparam int ZERO_HIGH_US   = 26;
  localparam int ONE_HIGH_US    = 70;
  localparam int THRESH_US      = 40;
  localparam int END_LOW_US     = 50;
  localparam int EDGE_TMO_US    = 100;
  localparam int FRAME_MS       = 4;
  localparam int POWERUP_MS     = 1000;
  localparam int SPACING_MS     = 1000;

  localparam int START_LOW_CYC  = START_LOW_MS * 1000 * CLK_MHZ;
  localparam int RESP_DLY_CYC   = RESP_DLY_US * CLK_MHZ;
  localparam int RESP_LOW_CYC   = RESP_LOW_US * CLK_MHZ;
  localparam int RESP_HIGH_CYC  = RESP_HIGH_US * CLK_MHZ;
  localparam int BIT_LOW_CYC    = BIT_LOW_US * CLK_MHZ;
  localparam int ZERO_HIGH_CYC  = ZERO_HIGH_US * CLK_MHZ;
  localparam int ONE_HIGH_CYC   = ONE_HIGH_US * CLK_MHZ;
  localparam int THRESH_CYC     = THRESH_US * CLK_MHZ;
  localparam int END_LOW_CYC    = END_LOW_US * CLK_MHZ;
  localparam int EDGE_TMO_CYC   = EDGE_TMO_US * CLK_MHZ;
  localparam int FRAME_CYC      = FRAME_MS * 1000 * CLK_MHZ;
  localparam int POWERUP_CYC    = POWERUP_MS * 1000 * CLK_MHZ;
  localparam int SPACING_CYC    = SPACING_MS * 1000 * CLK_MHZ;

  localparam logic [BIT_IDX_W-1:0] LAST_BIT = 6'h27;

  typedef enum logic [7:0] {
    S_SLEEP     = 8'h01,
    S_START_LOW = 8'h02,
    S_TURN      = 8'h04,
    S_RESP_LOW  = 8'h08,
    S_RESP_HIGH = 8'h10,
    S_BIT_LOW   = 8'h20,
    S_BIT_HIGH  = 8'h40,
    S_END_LOW   = 8'h80
  } hswl_sensor_state_t;

  typedef enum logic [7:0] {
    H_IDLE  = 8'h01,
    H_START = 8'h02,
    H_WAIT  = 8'h04,
    H_RLOW  = 8'h08,
    H_RHIGH = 8'h10,
    H_BLOW  = 8'h20,
    H_BHIGH = 8'h40,
    H_END   = 8'h80
  } hswl_host_state_t;
endpackage

// ---- hdl/hswl_if.sv ----
// shared open-drain data line between host and sensor
// each end drives low only while its enable is high; pull-up otherwise
interface hswl_if;
  logic host_out;
  logic host_oe;
  logic sensor_out;
  logic sensor_oe;
  logic line;

  // wired-and with pull-up: released line reads high
  assign line = ~((host_oe & ~host_out) | (sensor_oe & ~sensor_out));

  modport host (input line, output host_out, output host_oe);
  modport sensor (input line, output sensor_out, output sensor_oe);
endinterface

// ---- hdl/hswl_sensor.sv ----
// sensor end: waits for a start request, answers, sends a 40-bit frame
// assumes the host keeps its own timing; line level is synchronous
module hswl_sensor
  import hswl_pkg::*;
#(
  parameter int START_DET_CYC_P = START_LOW_CYC,
  parameter int RESP_DLY_CYC_P  = RESP_DLY_CYC,
  parameter int RESP_LOW_CYC_P  = RESP_LOW_CYC,
  parameter int RESP_HIGH_CYC_P = RESP_HIGH_CYC,
  parameter int BIT_LOW_CYC_P   = BIT_LOW_CYC,
  parameter int ZERO_HIGH_CYC_P = ZERO_HIGH_CYC,
  parameter int ONE_HIGH_CYC_P  = ONE_HIGH_CYC,
  parameter int END_LOW_CYC_P   = END_LOW_CYC
) (
  input  wire logic              clock_in,
  input  wire logic              rst_n_in,
  hswl_if.sensor                 link,
  input  wire logic [BYTE_W-1:0] hum_int_in,
  input  wire logic [BYTE_W-1:0] hum_dec_in,
  input  wire logic [BYTE_W-1:0] tmp_int_in,
  input  wire logic [BYTE_W-1:0] tmp_dec_in,
  output logic                   awake_out,
  output logic                   sending_out
);
  hswl_sensor_state_t        state_reg, state_next;
  logic [CNT_W-1:0]          cnt_reg, cnt_next;
  logic [BIT_IDX_W-1:0]      bit_reg, bit_next;
  logic [FRAME_BITS-1:0]     shift_reg, shift_next;
  logic                      oe_reg, oe_next;
  logic                      awake_reg, awake_next;
  logic                      send_reg, send_next;
  logic [BYTE_W+1:0]         sum_w;
  logic [CNT_W-1:0]          high_len;

  always_comb begin
    sum_w = {2'h0, hum_int_in} + {2'h0, hum_dec_in} + {2'h0, tmp_int_in} + {2'h0, tmp_dec_in};
  end

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg + 28'h1;
    bit_next   = bit_reg;
    shift_next = shift_reg;
    oe_next    = oe_reg;
    awake_next = awake_reg;
    send_next  = send_reg;
    high_len   = shift_reg[FRAME_BITS-1] ? CNT_W'(ONE_HIGH_CYC_P) : CNT_W'(ZERO_HIGH_CYC_P);
    case (state_reg)
      S_SLEEP: begin
        cnt_next = '0;
        if (!link.line) begin
          state_next = S_START_LOW;
          awake_next = 1'b1;
        end
      end
      S_START_LOW: begin
        if (cnt_reg == '1) begin
          cnt_next = cnt_reg;
        end
        if (link.line) begin
          cnt_next = '0;
          if (cnt_reg >= CNT_W'(START_DET_CYC_P - 1)) begin
            state_next = S_TURN;
            // snapshot the readings so the frame stays coherent
            shift_next = {hum_int_in, hum_dec_in, tmp_int_in, tmp_dec_in, sum_w[BYTE_W-1:0]};
          end else begin
            // too short: treat as a glitch and stay silent
            state_next = S_SLEEP;
            awake_next = 1'b0;
          end
        end
      end
      S_TURN: begin
        if (cnt_reg >= CNT_W'(RESP_DLY_CYC_P - 1)) begin
          state_next = S_RESP_LOW;
          cnt_next   = '0;
          oe_next    = 1'b1;
          send_next  = 1'b1;
        end
      end
      S_RESP_LOW: begin
        if (cnt_reg >= CNT_W'(RESP_LOW_CYC_P - 1)) begin
          state_next = S_RESP_HIGH;
          cnt_next   = '0;
          oe_next    = 1'b0;
        end
      end
      S_RESP_HIGH: begin
        if (cnt_reg >= CNT_W'(RESP_HIGH_CYC_P - 1)) begin
          state_next = S_BIT_LOW;
          cnt_next   = '0;
          bit_next   = '0;
          oe_next    = 1'b1;
        end
      end
      S_BIT_LOW: begin
        if (cnt_reg >= CNT_W'(BIT_LOW_CYC_P - 1)) begin
          state_next = S_BIT_HIGH;
          cnt_next   = '0;
          oe_next    = 1'b0;
        end
      end
      S_BIT_HIGH: begin
        if (cnt_reg >= high_len - 28'h1) begin
          cnt_next   = '0;
          oe_next    = 1'b1;
          shift_next = {shift_reg[FRAME_BITS-2:0], 1'b0};
          bit_next   = bit_reg + 6'h1;
          state_next = (bit_reg == LAST_BIT) ? S_END_LOW : S_BIT_LOW;
        end
      end
      S_END_LOW: begin
        if (cnt_reg >= CNT_W'(END_LOW_CYC_P - 1)) begin
          state_next = S_SLEEP;
          oe_next    = 1'b0;
          awake_next = 1'b0;
          send_next  = 1'b0;
        end
      end
      default: begin
        state_next = S_SLEEP;
        oe_next    = 1'b0;
        awake_next = 1'b0;
        send_next  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      state_reg <= S_SLEEP;
      cnt_reg   <= '0;
      bit_reg   <= '0;
      shift_reg <= '0;
      oe_reg    <= 1'b0;
      awake_reg <= 1'b0;
      send_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      bit_reg   <= bit_next;
      shift_reg <= shift_next;
      oe_reg    <= oe_next;
      awake_reg <= awake_next;
      send_reg  <= send_next;
    end
  end

  // open-drain: the level driven is always low, only the enable moves
  assign link.sensor_out = 1'b0;
  assign link.sensor_oe  = oe_reg;
  assign awake_out       = awake_reg;
  assign sending_out     = send_reg;
endmodule

// ---- hdl/hswl_host.sv ----
// host end: issues start requests, decodes the 40-bit frame
// assumes one sensor on the line; request is a one-cycle strobe
module hswl_host
  import hswl_pkg::*;
#(
  parameter int START_LOW_CYC_P = START_LOW_CYC,
  parameter int THRESH_CYC_P    = THRESH_CYC,
  parameter int EDGE_TMO_CYC_P  = EDGE_TMO_CYC,
  parameter int POWERUP_CYC_P   = POWERUP_CYC,
  parameter int SPACING_CYC_P   = SPACING_CYC
) (
  input  wire logic              clock_in,
  input  wire logic              rst_n_in,
  hswl_if.host                   link,
  input  wire logic              start_in,
  output logic                   ready_out,
  output logic                   busy_out,
  output logic [BYTE_W-1:0]      hum_int_out,
  output logic [BYTE_W-1:0]      hum_dec_out,
  output logic [BYTE_W-1:0]      tmp_int_out,
  output logic [BYTE_W-1:0]      tmp_dec_out,
  output logic                   valid_out,
  output logic                   chk_err_out,
  output logic                   no_resp_out,
  output logic                   timeout_out
);
  hswl_host_state_t          state_reg, state_next;
  logic [CNT_W-1:0]          cnt_reg, cnt_next;
  logic [CNT_W-1:0]          guard_reg, guard_next;
  logic [BIT_IDX_W-1:0]      bit_reg, bit_next;
  logic [FRAME_BITS-1:0]     shift_reg, shift_next;
  logic [4*BYTE_W-1:0]       data_reg, data_next;
  logic                      oe_reg, oe_next;
  logic                      ready_reg, ready_next;
  logic                      busy_reg, busy_next;
  logic                      valid_reg, valid_next;
  logic                      chk_reg, chk_next;
  logic                      nresp_reg, nresp_next;
  logic                      tmo_reg, tmo_next;
  logic [BYTE_W+1:0]         sum_w;
  logic                      tmo_hit;

  always_comb begin
    sum_w = {2'h0, shift_reg[39:32]} + {2'h0, shift_reg[31:24]}
          + {2'h0, shift_reg[23:16]} + {2'h0, shift_reg[15:8]};
  end

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg + 28'h1;
    guard_next = (guard_reg != '0) ? guard_reg - 28'h1 : guard_reg;
    bit_next   = bit_reg;
    shift_next = shift_reg;
    data_next  = data_reg;
    oe_next    = oe_reg;
    busy_next  = busy_reg;
    valid_next = 1'b0;
    chk_next   = 1'b0;
    nresp_next = 1'b0;
    tmo_next   = 1'b0;
    // a missing edge within the window aborts the frame
    tmo_hit    = cnt_reg >= CNT_W'(EDGE_TMO_CYC_P - 1);
    case (state_reg)
      H_IDLE: begin
        cnt_next = '0;
        // a start while guarded or busy is dropped, never queued
        if (start_in && ready_reg) begin
          state_next = H_START;
          oe_next    = 1'b1;
          busy_next  = 1'b1;
          guard_next = CNT_W'(SPACING_CYC_P);
        end
      end
      H_START: begin
        if (cnt_reg >= CNT_W'(START_LOW_CYC_P - 1)) begin
          state_next = H_WAIT;
          cnt_next   = '0;
          oe_next    = 1'b0;
        end
      end
      H_WAIT: begin
        if (!link.line) begin
          state_next = H_RLOW;
          cnt_next   = '0;
        end else if (tmo_hit) begin
          state_next = H_IDLE;
          nresp_next = 1'b1;
          busy_next  = 1'b0;
        end
      end
      H_RLOW: begin
        // answer low under way; wait for the line to come back high
        if (link.line) begin
          state_next = H_RHIGH;
          cnt_next   = '0;
        end else if (tmo_hit) begin
          state_next = H_IDLE;
          tmo_next   = 1'b1;
          busy_next  = 1'b0;
        end
      end
      H_RHIGH: begin
        // the fall that ends the preamble opens the first data bit
        if (!link.line) begin
          state_next = H_BLOW;
          cnt_next   = '0;
          bit_next   = '0;
        end else if (tmo_hit) begin
          state_next = H_IDLE;
          tmo_next   = 1'b1;
          busy_next  = 1'b0;
        end
      end
      H_BLOW: begin
        if (link.line) begin
          state_next = H_BHIGH;
          cnt_next   = '0;
        end else if (tmo_hit) begin
          state_next = H_IDLE;
          tmo_next   = 1'b1;
          busy_next  = 1'b0;
        end
      end
      H_BHIGH: begin
        if (!link.line) begin
          cnt_next   = '0;
          shift_next = {shift_reg[FRAME_BITS-2:0], cnt_reg >= CNT_W'(THRESH_CYC_P)};
          bit_next   = bit_reg + 6'h1;
          state_next = (bit_reg == LAST_BIT) ? H_END : H_BLOW;
        end else if (tmo_hit) begin
          state_next = H_IDLE;
          tmo_next   = 1'b1;
          busy_next  = 1'b0;
        end
      end
      H_END: begin
        if (link.line) begin
          state_next = H_IDLE;
          busy_next  = 1'b0;
          // held readings are only replaced by a frame whose sum agrees
          if (sum_w[BYTE_W-1:0] == shift_reg[7:0]) begin
            data_next  = shift_reg[39:8];
            valid_next = 1'b1;
          end else begin
            chk_next = 1'b1;
          end
        end else if (tmo_hit) begin
          state_next = H_IDLE;
          tmo_next   = 1'b1;
          busy_next  = 1'b0;
        end
      end
      default: begin
        state_next = H_IDLE;
        oe_next    = 1'b0;
        busy_next  = 1'b0;
      end
    endcase
    ready_next = (state_next == H_IDLE) && (guard_next == '0);
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      state_reg <= H_IDLE;
      cnt_reg   <= '0;
      guard_reg <= CNT_W'(POWERUP_CYC_P);
      bit_reg   <= '0;
      shift_reg <= '0;
      data_reg  <= '0;
      oe_reg    <= 1'b0;
      ready_reg <= 1'b0;
      busy_reg  <= 1'b0;
      valid_reg <= 1'b0;
      chk_reg   <= 1'b0;
      nresp_reg <= 1'b0;
      tmo_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      guard_reg <= guard_next;
      bit_reg   <= bit_next;
      shift_reg <= shift_next;
      data_reg  <= data_next;
      oe_reg    <= oe_next;
      ready_reg <= ready_next;
      busy_reg  <= busy_next;
      valid_reg <= valid_next;
      chk_reg   <= chk_next;
      nresp_reg <= nresp_next;
      tmo_reg   <= tmo_next;
    end
  end

  // open-drain: only the enable moves, driven level is low
  assign link.host_out = 1'b0;
  assign link.host_oe  = oe_reg;
  assign ready_out     = ready_reg;
  assign busy_out      = busy_reg;
  assign hum_int_out   = data_reg[31:24];
  assign hum_dec_out   = data_reg[23:16];
  assign tmp_int_out   = data_reg[15:8];
  assign tmp_dec_out   = data_reg[7:0];
  assign valid_out     = valid_reg;
  assign chk_err_out   = chk_reg;
  assign no_resp_out   = nresp_reg;
  assign timeout_out   = tmo_reg;
endmodule

// ---- sim/hswl_assertions.sv ----
// checker for the open-drain line shared by host and sensor
// assumes one clock; interface signals are wired in as plain inputs
module hswl_assertions
  import hswl_pkg::*;
#(
  parameter int START_LOW_CYC_P = 200,
  parameter int RESP_DLY_CYC_P  = 20,
  parameter int RESP_LOW_CYC_P  = 40,
  parameter int RESP_HIGH_CYC_P = 40,
  parameter int BIT_LOW_CYC_P   = 25,
  parameter int ZERO_HIGH_CYC_P = 13,
  parameter int ONE_HIGH_CYC_P  = 35,
  parameter int END_LOW_CYC_P   = 25
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic host_out,
  input wire logic host_oe,
  input wire logic sensor_out,
  input wire logic sensor_oe,
  input wire logic line
);
  timeunit 1ns;
  timeprecision 1ps;
  // slack around the sensor's chosen turnaround count
  localparam int TURN_LO = RESP_DLY_CYC_P - 2;
  localparam int TURN_HI = RESP_DLY_CYC_P + 3;
  localparam int RISES   = FRAME_BITS + 2;
  int   h_hi_reg, h_hi_next, s_hi_reg, s_hi_next, s_lo_reg, s_lo_next, rise_reg, rise_next;
  logic oe_q_reg, oe_q_next;

  always_comb begin
    h_hi_next = host_oe ? h_hi_reg + 1 : 0;
    s_hi_next = sensor_oe ? s_hi_reg + 1 : 0;
    s_lo_next = sensor_oe ? 0 : s_lo_reg + 1;
    oe_q_next = sensor_oe;
    rise_next = host_oe ? 0 : rise_reg + int'(sensor_oe & ~oe_q_reg);
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      h_hi_reg <= 0;
      s_hi_reg <= 0;
      s_lo_reg <= 0;
      oe_q_reg <= 1'b0;
      rise_reg <= 0;
    end else begin
      h_hi_reg <= h_hi_next;
      s_hi_reg <= s_hi_next;
      s_lo_reg <= s_lo_next;
      oe_q_reg <= oe_q_next;
      rise_reg <= rise_next;
    end
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_release;
    $fell(host_oe);
  endsequence
  sequence s_answer;
    !sensor_oe ##[TURN_LO:TURN_HI] $rose(sensor_oe);
  endsequence

  property p_open_drain; host_out == 1'b0 && sensor_out == 1'b0; endproperty
  property p_idle_high; (!host_oe && !sensor_oe) |-> line; endproperty
  property p_start_len; s_release |-> h_hi_reg == START_LOW_CYC_P; endproperty
  property p_turnaround; s_release |=> s_answer; endproperty
  property p_no_clash; !(host_oe && sensor_oe); endproperty
  property p_low_len;
    $fell(sensor_oe) |->
      (s_hi_reg == RESP_LOW_CYC_P || s_hi_reg == BIT_LOW_CYC_P || s_hi_reg == END_LOW_CYC_P);
  endproperty
  property p_high_len;
    ($rose(sensor_oe) && s_lo_reg <= RESP_HIGH_CYC_P) |->
      (s_lo_reg == RESP_HIGH_CYC_P || s_lo_reg == ZERO_HIGH_CYC_P || s_lo_reg == ONE_HIGH_CYC_P);
  endproperty
  property p_quiet; $rose(sensor_oe) |-> rise_reg < RISES; endproperty
  property p_frame_len; $rose(host_oe) |-> (rise_reg == 0 || rise_reg == RISES); endproperty

  a_open_drain: assert property (p_open_drain)
    else $error("line data driven high");
  a_idle_high: assert property (p_idle_high)
    else $error("released line not high");
  a_start_len: assert property (p_start_len)
    else $error("start pulse length wrong");
  a_turnaround: assert property (p_turnaround)
    else $error("answer delay wrong");
  a_no_clash: assert property (p_no_clash)
    else $error("both ends pull line");
  a_low_len: assert property (p_low_len)
    else $error("sensor low period wrong");
  a_high_len: assert property (p_high_len)
    else $error("sensor high period wrong");
  a_quiet: assert property (p_quiet)
    else $error("sensor drives outside frame");
  a_frame_len: assert property (p_frame_len)
    else $error("frame pulse count wrong");
endmodule

// ---- sim/hswl_tb.sv ----
// bench: host and sensor face each other; a second host sees a faulty far end
// assumes shortened timing counts; results checked against a queue of notes
module hswl_tb
  import hswl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ST = 200, DLY = 20, RL = 40, RH = 40, BL = 25, ZH = 13, OH = 35, TH = 20;
  localparam int EL = 25, TMO = 60, PU = 3000, SP = 3000, LIMIT = 40000;
  logic clock_in, rst_n_in, start_in, start2_in, bad_oe, ready, busy, ready2, busy2;
  logic valid, chk, nresp, tmo, valid2, chk2, nresp2, tmo2, awake, sending;
  logic [BYTE_W-1:0] hi, hd, ti, td, d1, d2, d3, d4;
  logic [39:0] q[$];
  logic [39:0] e, exp_word, wbits;
  logic prev_line, prev_send;
  int nfall, hlen, num_errors, samples_checked, cyc, pu_n;

  hswl_if link_if();
  hswl_if bad_if();
  // far end of the second link: never answers, or sticks low
  assign bad_if.sensor_out = 1'b0;
  assign bad_if.sensor_oe = bad_oe;

  hswl_host #(.START_LOW_CYC_P(ST), .THRESH_CYC_P(TH), .EDGE_TMO_CYC_P(TMO),
    .POWERUP_CYC_P(PU), .SPACING_CYC_P(SP)) hswl_host_i (.clock_in(clock_in),
    .rst_n_in(rst_n_in), .link(link_if.host), .start_in(start_in), .ready_out(ready),
    .busy_out(busy), .hum_int_out(d1), .hum_dec_out(d2), .tmp_int_out(d3), .tmp_dec_out(d4),
    .valid_out(valid), .chk_err_out(chk), .no_resp_out(nresp), .timeout_out(tmo));
  hswl_host #(.START_LOW_CYC_P(ST), .THRESH_CYC_P(TH), .EDGE_TMO_CYC_P(TMO),
    .POWERUP_CYC_P(PU), .SPACING_CYC_P(SP)) hswl_host_i2 (.clock_in(clock_in),
    .rst_n_in(rst_n_in), .link(bad_if.host), .start_in(start2_in), .ready_out(ready2),
    .busy_out(busy2), .hum_int_out(), .hum_dec_out(), .tmp_int_out(), .tmp_dec_out(),
    .valid_out(valid2), .chk_err_out(chk2), .no_resp_out(nresp2), .timeout_out(tmo2));
  hswl_sensor #(.START_DET_CYC_P(ST), .RESP_DLY_CYC_P(DLY), .RESP_LOW_CYC_P(RL),
    .RESP_HIGH_CYC_P(RH), .BIT_LOW_CYC_P(BL), .ZERO_HIGH_CYC_P(ZH), .ONE_HIGH_CYC_P(OH),
    .END_LOW_CYC_P(EL)) hswl_sensor_i (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .link(link_if.sensor), .hum_int_in(hi), .hum_dec_in(hd), .tmp_int_in(ti), .tmp_dec_in(td),
    .awake_out(awake), .sending_out(sending));
  hswl_assertions #(.START_LOW_CYC_P(ST), .RESP_DLY_CYC_P(DLY), .RESP_LOW_CYC_P(RL),
    .RESP_HIGH_CYC_P(RH), .BIT_LOW_CYC_P(BL), .ZERO_HIGH_CYC_P(ZH), .ONE_HIGH_CYC_P(OH),
    .END_LOW_CYC_P(EL)) hswl_assertions_i (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .host_out(link_if.host_out), .host_oe(link_if.host_oe), .sensor_out(link_if.sensor_out),
    .sensor_oe(link_if.sensor_oe), .line(link_if.line));

  task check(input logic [39:0] seen, input logic [39:0] expv);
    samples_checked++;
    if (seen !== expv) begin
      num_errors++;
      $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, expv);
    end
  endtask

  task summarize;
    if (num_errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end

  always @(posedge clock_in) begin
    cyc++;
    if (cyc == LIMIT) begin
      num_errors++;
      summarize();
    end
  end

  // results and the wire itself, sampled where settled
  always @(negedge clock_in) begin
    if ((|{valid, chk, nresp, tmo, valid2, chk2, nresp2, tmo2}) === 1'b1) begin
      e = (q.size() > 0) ? q.pop_front() : '1;
      if ((|{valid, chk, nresp, tmo}) === 1'b1) begin
        check({4'h0, valid, chk, nresp, tmo, d1, d2, d3, d4}, e);
      end else begin
        check({4'h1, valid2, chk2, nresp2, tmo2, 32'h0}, e);
      end
    end
    if (link_if.host_oe === 1'b1) begin
      nfall = 0;
      hlen = 0;
    end else begin
      if (prev_line === 1'b1 && link_if.line === 1'b0) begin
        nfall++;
        if (nfall >= 3 && nfall <= 42) begin
          wbits = {wbits[38:0], hlen >= TH};
          check(hlen, exp_word[42-nfall] ? OH : ZH);
        end
      end
      hlen = (link_if.line === 1'b1) ? hlen + 1 : 0;
    end
    prev_line = link_if.line;
    if (prev_send === 1'b1 && sending === 1'b0) begin
      check(wbits, exp_word);
      check({nfall, awake}, {32'd42, 1'b0});
    end
    prev_send = sending;
  end

  task automatic xfer(input logic [31:0] d, input bit poke);
    @(negedge clock_in);
    {hi, hd, ti, td} = d;
    exp_word = {d, d[31:24] + d[23:16] + d[15:8] + d[7:0]};
    while (ready !== 1'b1) @(negedge clock_in);
    start_in = 1'b1;
    q.push_back({8'h08, d});
    @(negedge clock_in);
    start_in = 1'b0;
    check({busy, ready, link_if.host_oe}, 3'b101);
    if (poke) begin
      // inputs already sampled; a start while busy must be ignored
      repeat (300) @(negedge clock_in);
      start_in = 1'b1;
      {hi, hd, ti, td} = $urandom;
      @(negedge clock_in);
      start_in = 1'b0;
    end
    while (busy !== 1'b0) @(negedge clock_in);
    check(ready, 1'b0);
  endtask

  task automatic bad(input bit stuck);
    while (ready2 !== 1'b1) @(negedge clock_in);
    start2_in = 1'b1;
    q.push_back({4'h1, stuck ? 4'b0001 : 4'b0010, 32'h0});
    @(negedge clock_in);
    start2_in = 1'b0;
    while (bad_if.host_oe !== 1'b0) @(negedge clock_in);
    repeat (5) @(negedge clock_in);
    bad_oe = stuck;
    while (busy2 !== 1'b0) @(negedge clock_in);
    bad_oe = 1'b0;
  endtask

  initial begin
    {rst_n_in, start_in, start2_in, bad_oe, hi, hd, ti, td} = '0;
    {prev_line, prev_send, wbits, exp_word} = '0;
    void'($urandom(32'h9fe80856));
    repeat (10) @(negedge clock_in);
    rst_n_in = 1'b1;
    start_in = 1'b1;
    repeat (100) @(negedge clock_in);
    start_in = 1'b0;
    check({ready, link_if.host_oe}, 2'b00);
    pu_n = 100;
    while (ready !== 1'b1) begin
      @(negedge clock_in);
      pu_n++;
    end
    check(pu_n >= PU - 3 && pu_n <= PU + 3, 1'b1);
    xfer(32'h0000_0000, 1'b1);
    xfer(32'hFFFF_FFFF, 1'b0);
    repeat (2) xfer($urandom, 1'b0);
    bad(1'b0);
    bad(1'b1);
    repeat (20) @(negedge clock_in);
    check(q.size(), 0);
    summarize();
  end
endmodule
